// *** host_pins.sv ***
// host-side model that drives the modulation pins of the nco block
`timescale 1ns/10ps
`default_nettype none
module host_pins (
    input  wire logic aclk,
    output var  logic offset_freq_enable,
    output var  logic phase_select_lo,
    output var  logic phase_select_hi,
    output var  logic update_n
);
    // ==========================================
    // pin drivers
    // pins idle with no offset, quadrant zero and update released
    initial begin
        offset_freq_enable = 1'b0;
        phase_select_lo = 1'b0;
        phase_select_hi = 1'b0;
        update_n = 1'b1;
    end
    // both quadrant pins change together on one edge
    task set_phase(input logic [1:0] q);
        @(posedge aclk);
        phase_select_hi <= q[1];
        phase_select_lo <= q[0];
    endtask
    // update held low two cycles so the synchroniser sees its falling edge
    task pulse_update;
        @(posedge aclk);
        update_n <= 1'b0;
        repeat (2) @(posedge aclk);
        update_n <= 1'b1;
    endtask
    // tones switch by the offset pin alone, toggled on every clock edge
    task ofr_pattern;
        repeat (2) begin
            @(posedge aclk);
            offset_freq_enable <= 1'b1;
            @(posedge aclk);
            offset_freq_enable <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** nco_defines.svh ***
// shared constants for the nco modulation control block
`ifndef NCO_DEFINES_SVH
`define NCO_DEFINES_SVH
// register byte offsets
`define OFS_CENTER_LO  12'h000
`define OFS_CENTER_HI  12'h004
`define OFS_OFFSET_LO  12'h008
`define OFS_OFFSET_HI  12'h00C
`define OFS_CONTROL    12'h010
`define OFS_STATUS     12'h014
// control field positions
`define CTL_ACC_RUN    5
`define CTL_UPDATE     0
// reset values
`define RST_CENTER_LO  32'h00000000
`define RST_CENTER_HI  32'h00004000
`define RST_CONTROL    32'h00000020
// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
// latency from offset pin to dac
`define OFR_LATENCY    14
`define SYNC_STAGES    2
`define PIPE_TAIL      6
`endif

// *** nco_modulation_control.sv ***
// nco with fsk, psk and accumulator reset, 14-bit dac code outputs
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "nco_defines.svh"
module nco_modulation_control #(
    parameter int ACC_W = 48,
    parameter int DAC_W = 14
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        offset_freq_enable,
    input  wire logic        phase_select_lo,
    input  wire logic        phase_select_hi,
    input  wire logic        update_n,
    output var  logic [13:0] dac_out_true,
    output var  logic [13:0] dac_out_comp,
    output var  logic        dac_valid,
    input  wire logic        dac_ready
);
    // =====================================================================
    // register file
    // =====================================================================
    logic [31:0] center_lo_r;     // master centre word low
    logic [31:0] center_hi_r;     // master centre word high
    logic [31:0] offset_lo_r;     // master offset word low
    logic [31:0] offset_hi_r;     // master offset word high
    logic [31:0] control_r;       // run bit only, update bit not stored
    logic [ACC_W-1:0] center_act_r; // active centre word
    logic [ACC_W-1:0] offset_act_r; // active offset word
    logic        upd_strobe_r;    // software update pulse
    logic        have_aw_r;       // write address captured
    logic        have_w_r;        // write data captured
    logic [11:0] aw_addr_r;       // captured write address
    logic [31:0] w_data_r;        // captured write data
    logic [3:0]  w_strb_r;        // captured strobes
    nco_pkg::wr_state_e wr_state_r; // write pipeline
    logic [3:0]  ph_sync;         // {update_n, ofr, hi, lo}
    logic        acc_run_r;       // run bit, pipelined
    nco_pkg::dac_word_s buf_in;   // true and complement codes
    nco_pkg::dac_word_s buf_out;  // buffered sample
    logic        buf_in_ready;    // buffer can accept
    logic        buf_out_valid;   // buffer holds a sample
    // byte-lane merge used for every writable register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction
    // address decode
    function automatic logic known(input logic [11:0] a);
        return (a == `OFS_CENTER_LO) || (a == `OFS_CENTER_HI) ||
               (a == `OFS_OFFSET_LO) || (a == `OFS_OFFSET_HI) ||
               (a == `OFS_CONTROL)   || (a == `OFS_STATUS);
    endfunction
    wire wr_fire = have_aw_r && have_w_r && (wr_state_r == nco_pkg::WR_IDLE);
    wire [11:0] wa = {aw_addr_r[11:2], 2'h0};
    // =====================================================================
    // axi write channel
    // =====================================================================
    assign s_axi_awready = !have_aw_r && (wr_state_r == nco_pkg::WR_IDLE);
    assign s_axi_wready  = !have_w_r && (wr_state_r == nco_pkg::WR_IDLE);
    // capture address and data in any order, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw_r    <= 1'b0;
            have_w_r     <= 1'b0;
            aw_addr_r    <= 12'h000;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
            wr_state_r   <= nco_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            unique case (wr_state_r)
                nco_pkg::WR_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        have_aw_r <= 1'b1;
                        aw_addr_r <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        have_w_r <= 1'b1;
                        w_data_r <= s_axi_wdata;
                        w_strb_r <= s_axi_wstrb;
                    end
                    if (wr_fire) begin
                        have_aw_r    <= 1'b0;
                        have_w_r     <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= known(wa) ? `RESP_OKAY : `RESP_SLVERR;
                        wr_state_r   <= nco_pkg::WR_RESP;
                    end
                end
                nco_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_r   <= nco_pkg::WR_IDLE;
                    end
                end
            endcase
        end
    end
    // master registers, one word per write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            center_lo_r  <= `RST_CENTER_LO;
            center_hi_r  <= `RST_CENTER_HI;
            offset_lo_r  <= 32'h00000000;
            offset_hi_r  <= 32'h00000000;
            control_r    <= `RST_CONTROL;
            upd_strobe_r <= 1'b0;
        end else begin
            upd_strobe_r <= 1'b0;
            if (wr_fire) begin
                if (wa == `OFS_CENTER_LO) begin
                    center_lo_r <= merge(center_lo_r, w_data_r, w_strb_r);
                end
                if (wa == `OFS_CENTER_HI) begin
                    center_hi_r <= merge(center_hi_r, w_data_r, w_strb_r) & 32'h0000FFFF;
                end
                if (wa == `OFS_OFFSET_LO) begin
                    offset_lo_r <= merge(offset_lo_r, w_data_r, w_strb_r);
                end
                if (wa == `OFS_OFFSET_HI) begin
                    offset_hi_r <= merge(offset_hi_r, w_data_r, w_strb_r) & 32'h0000FFFF;
                end
                if (wa == `OFS_CONTROL) begin
                    control_r <= merge(control_r, w_data_r, w_strb_r) & 32'h00000020;
                    upd_strobe_r <= w_strb_r[0] && w_data_r[`CTL_UPDATE];
                end
            end
        end
    end
    // =====================================================================
    // axi read channel
    // =====================================================================
    wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
    wire [31:0] status_word = {29'h0, acc_run_r, ph_sync[1:0]};
    wire [31:0] rd_mux =
        (ra == `OFS_CENTER_LO) ? center_lo_r :
        (ra == `OFS_CENTER_HI) ? center_hi_r :
        (ra == `OFS_OFFSET_LO) ? offset_lo_r :
        (ra == `OFS_OFFSET_HI) ? offset_hi_r :
        (ra == `OFS_CONTROL)   ? control_r   :
        (ra == `OFS_STATUS)    ? status_word : 32'h00000000;
    assign s_axi_arready = !s_axi_rvalid;
    // one read at a time, answered the cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= known(ra) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // =====================================================================
    // pin synchronisers
    // =====================================================================
    nco_sync #(.W(4)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({update_n, offset_freq_enable, phase_select_hi, phase_select_lo}),
        .q       (ph_sync)
    );
    logic upd_pin_d_r;  // previous update level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upd_pin_d_r <= 1'b0;  // matches synchroniser reset, no false fall
        end else begin
            upd_pin_d_r <= ph_sync[3];
        end
    end
    wire do_update = upd_strobe_r || (upd_pin_d_r && !ph_sync[3]);
    // master to active transfer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            center_act_r <= {center_hi_r[15:0], center_lo_r};
            offset_act_r <= 48'h0;
        end else if (do_update) begin
            center_act_r <= {center_hi_r[15:0], center_lo_r};
            offset_act_r <= {offset_hi_r[15:0], offset_lo_r};
        end
    end
    // =====================================================================
    // datapath pipeline
    // =====================================================================
    // stage delays chosen so that pin sync (2) + pipe totals 14
    localparam int PRE = `OFR_LATENCY - `SYNC_STAGES - `PIPE_TAIL;
    logic [PRE-1:0] ofr_pipe_r;   // offset enable delay line
    logic [1:0]     quad_pipe_r [PRE+1]; // phase select delay line
    logic [ACC_W-1:0] fword_r;    // frequency word to accumulator
    logic [ACC_W-1:0] acc_r;      // phase accumulator
    logic [1:0]     quad_r;       // quadrant aligned with acc
    logic [DAC_W-1:0] phase_r;    // phase after quadrant offset
    logic [DAC_W-1:0] amp_r;      // amplitude code
    // delay lines keep every pin change in order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ofr_pipe_r <= '0;
            for (int i = 0; i <= PRE; i++) begin
                quad_pipe_r[i] <= 2'h0;
            end
        end else begin
            ofr_pipe_r <= {ofr_pipe_r[PRE-2:0], ph_sync[2]};
            quad_pipe_r[0] <= {ph_sync[1], ph_sync[0]};
            for (int i = 1; i <= PRE; i++) begin
                quad_pipe_r[i] <= quad_pipe_r[i-1];
            end
        end
    end
    wire ofr_late = ofr_pipe_r[PRE-1];
    // frequency sum, then accumulate, then phase map
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_run_r <= 1'b1;
            fword_r   <= '0;
            acc_r     <= '0;
            quad_r    <= 2'h0;
            phase_r   <= '0;
        end else begin
            acc_run_r <= control_r[`CTL_ACC_RUN];
            fword_r   <= center_act_r + (ofr_late ? offset_act_r : '0);
            acc_r     <= acc_run_r ? (acc_r + fword_r) : '0;
            quad_r    <= quad_pipe_r[PRE];
            // quadrant added to top bits so restart phase is pin only
            phase_r   <= acc_r[ACC_W-1 -: DAC_W] + {quad_r, 12'h000};
        end
    end
    // triangle amplitude by quadrant symmetry, folded from the low phase bits, no table
    wire [11:0] q_idx  = phase_r[12] ? ~phase_r[11:0] : phase_r[11:0];
    wire [12:0] q_amp  = q_idx[11:0] + {1'b0, q_idx[11:0]} - 13'h0;
    wire [DAC_W-1:0] half = 14'h2000;
    wire [DAC_W-1:0] mag  = {1'b0, q_amp};
    wire [DAC_W-1:0] amp_nxt = phase_r[13] ? (half - mag[13:1]) : (half + mag[13:1]);
    logic amp_v_r;  // amplitude stage valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amp_r   <= 14'h2000;
            amp_v_r <= 1'b0;
        end else if (buf_in_ready) begin
            amp_r   <= amp_nxt;
            amp_v_r <= 1'b1;
        end
    end
    // =====================================================================
    // output buffer and dac register
    // =====================================================================
    assign buf_in.code_true = amp_r;
    assign buf_in.code_comp = ~amp_r;
    nco_skid #(.W(28)) u_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (amp_v_r),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (dac_ready || !dac_valid),
        .out_data  (buf_out)
    );
    // registered dac outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_out_true <= 14'h2000;
            dac_out_comp <= 14'h1FFF;
            dac_valid    <= 1'b0;
        end else if (dac_ready || !dac_valid) begin
            dac_valid <= buf_out_valid;
            if (buf_out_valid) begin
                dac_out_true <= buf_out.code_true;
                dac_out_comp <= buf_out.code_comp;
            end
        end
    end
    // =====================================================================
    // checks
    // =====================================================================
    chk_comp_sum: assert property (@(posedge aclk) disable iff (!aresetn)
        (dac_out_true + dac_out_comp) == 14'h3FFF)
        else $error("dac outputs not complementary");
    chk_acc_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !acc_run_r |=> acc_r == '0)
        else $error("accumulator not held at zero");
    chk_ofr_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        ofr_late == $past(ph_sync[2], PRE))
        else $error("offset enable delay wrong");
    chk_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("write not answered");
    chk_quad_pipe: assert property (@(posedge aclk) disable iff (!aresetn)
        quad_r == $past(quad_pipe_r[0], PRE+1))
        else $error("phase select delay wrong");
    chk_freq_sum: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |->
        fword_r == $past(center_act_r) + ($past(ofr_late) ? $past(offset_act_r) : '0))
        else $error("frequency word wrong");
    chk_restart_ph: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(acc_run_r) |=> phase_r == {$past(quad_r), 12'h000})
        else $error("restart phase not from pins");
    chk_rd_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule
`default_nettype wire

// *** nco_modulation_control_tb.sv ***
// self-checking testbench for the nco modulation control block
`timescale 1ns/10ps
`default_nettype none
`include "nco_defines.svh"
module nco_modulation_control_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, dac_ready = 1'b1, cap = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        offset_freq_enable, phase_select_lo, phase_select_hi, update_n, dac_valid;
    logic [13:0] dac_out_true, dac_out_comp, held_r, hold_r, v [4];
    logic [13:0] acc_q [$];
    logic        stall_r = 1'b0;
    int          failures = 0, cmp_count = 0, n, k, hits, first, last;

    // ==========================================
    // clock, partner and design
    always #5 aclk = ~aclk;
    host_pins HOST (.aclk, .offset_freq_enable, .phase_select_lo, .phase_select_hi, .update_n);
    nco_modulation_control DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .offset_freq_enable, .phase_select_lo,
        .phase_select_hi, .update_n, .dac_out_true, .dac_out_comp, .dac_valid, .dac_ready);

    // ==========================================
    // report and compare
    task tally_and_finish;
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task chk_code(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t dac code %h expected %h", $time, got, exp);
        end
    endtask
    // a wait that ran out of cycles ends the run
    task give_up;
        failures++;
        $display("[FAIL] %0t wait limit reached", $time);
        tally_and_finish();
    endtask

    // ==========================================
    // register bus master, entered just after a rising edge
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (n >= 50) give_up();
        chk_val({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (n >= 50) give_up();
        chk_val(s_axi_rdata, ed);
        chk_val({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // ==========================================
    // sample monitor: complement, stall hold and capture of accepted words
    always @(posedge aclk) begin
        if (aresetn && dac_valid === 1'b1) chk_code(dac_out_comp, ~dac_out_true);
        if (stall_r) chk_code(dac_out_true, hold_r);
        if (cap && dac_valid === 1'b1 && dac_ready) acc_q.push_back(dac_out_true);
        stall_r <= aresetn && dac_valid === 1'b1 && !dac_ready;
        hold_r <= dac_out_true;
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        chk_code(dac_out_true, 14'h2000);
        chk_code(dac_out_comp, 14'h1FFF);
        chk_val({31'h0, dac_valid}, 32'h0);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, unmapped places and back-to-back writes
        axi_rd(`OFS_CENTER_HI, `RST_CENTER_HI, `RESP_OKAY);
        axi_rd(`OFS_CONTROL, `RST_CONTROL, `RESP_OKAY);
        axi_rd(`OFS_STATUS, 32'h4, `RESP_OKAY);
        axi_rd(12'h018, 32'h0, `RESP_SLVERR);
        axi_wr(12'h0FC, 32'h1, `RESP_SLVERR);
        axi_wr(`OFS_OFFSET_LO, 32'h12345678, `RESP_OKAY);
        axi_wr(`OFS_OFFSET_LO, 32'h0, `RESP_OKAY);
        axi_rd(`OFS_OFFSET_LO, 32'h0, `RESP_OKAY);
        axi_wr(`OFS_OFFSET_HI, 32'h4000, `RESP_OKAY);
        // accumulator held at zero, each quadrant's held code differs from the one before
        axi_wr(`OFS_CONTROL, 32'h0, `RESP_OKAY);
        for (int q = 0; q < 4; q++) begin
            HOST.set_phase(q[1:0]);
            repeat (30) @(posedge aclk);
            v[q] = dac_out_true;
            repeat (8) @(posedge aclk);
            chk_code(dac_out_true, v[q]);
            if (q > 0) chk_val({31'h0, v[q] !== v[q-1]}, 32'h1);
            axi_rd(`OFS_STATUS, {30'h0, q[1:0]}, `RESP_OKAY);
        end
        // restart from zero at quarter-turn rate, with a stall on the output;
        // the oscillator runs free, so the stall spans whole periods of four
        HOST.set_phase(2'h0);
        axi_wr(`OFS_CONTROL, 32'h20, `RESP_OKAY);
        repeat (20) @(posedge aclk);
        cap <= 1'b1;
        repeat (4) @(posedge aclk);
        dac_ready <= 1'b0;
        repeat (4) @(posedge aclk);
        dac_ready <= 1'b1;
        n = 0;
        while (acc_q.size() < 16 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 200) give_up();
        cap <= 1'b0;
        for (int i = 0; i < 12; i++) chk_code(acc_q[i+4], acc_q[i]);
        hits = 0;
        for (int j = 0; j < 4; j++) begin
            n = 0;
            for (int i = 0; i < 4; i++) n += int'(acc_q[i] === v[(i+j)%4]);
            hits += int'(n == 4);
        end
        chk_val({31'h0, hits > 0}, 32'h1);
        // two-tone keying: centre zero, offset a quarter turn gated by the pin
        axi_wr(`OFS_CENTER_LO, 32'h0, `RESP_OKAY);
        axi_wr(`OFS_CENTER_HI, 32'h0, `RESP_OKAY);
        HOST.pulse_update();
        axi_wr(`OFS_CONTROL, 32'h0, `RESP_OKAY);
        axi_wr(`OFS_CONTROL, 32'h21, `RESP_OKAY);
        repeat (20) @(posedge aclk);
        first = 0;
        last = 0;
        hits = 0;
        k = -1;
        fork
            HOST.ofr_pattern();
            repeat (60) begin
                @(posedge aclk);
                #1;
                if (k >= 0) k++;
                else if (offset_freq_enable) k = 0;
                if (k > 0 && dac_out_true !== held_r) begin
                    hits++;
                    if (first == 0) first = k;
                    last = k;
                end
                held_r = dac_out_true;
            end
        join
        chk_val(32'(first), 32'(`OFR_LATENCY));
        chk_val(32'(hits), 32'h2);
        chk_val(32'(last - first), 32'h2);
        @(posedge aclk);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** nco_pkg.sv ***
// types shared by the nco modulation control files
package nco_pkg;
    // one dac sample, true code and its complement
    typedef struct packed {
        logic [13:0] code_true;
        logic [13:0] code_comp;
    } dac_word_s;
    // write pipeline states
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } wr_state_e;
endpackage

// *** nco_skid.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module nco_skid #(
    parameter int W = 28
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];   // storage
    logic         wp_r;        // write pointer
    logic         rp_r;        // read pointer
    logic [1:0]   cnt_r;       // fill level
    wire          push = in_valid && (cnt_r != 2'h2);
    wire          pop  = out_valid && out_ready;
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];
    // pointers and level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
    // data store
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule
`default_nettype wire

// *** nco_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module nco_sync #(
    parameter int W = 3
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;  // first stage, read only by q
    // two stage capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire
